/* verilog/branch_stack_pkg.sv */
// Purpose: Shared constants for the branch, stack and reset instruction group
// Assumes: 16-bit instruction words, 21-bit byte program counter
// Notes: Opcode patterns and field positions used by the executor
package branch_stack_pkg;
  localparam int PC_W = 21;
  localparam int STK_DEPTH = 31;
  localparam int STK_PTR_W = 5;
  localparam logic [7:0] OP_BRANCH_NEG = 8'he6;
  localparam logic [7:0] OP_BRANCH_NOT_CARRY = 8'he3;
  localparam logic [7:0] OP_BRANCH_NOT_NEG = 8'he7;
  localparam logic [4:0] OP_REL_CALL = 5'h1b;
  localparam logic [15:0] OP_STACK_POP = 16'h0006;
  localparam logic [15:0] OP_STACK_PUSH = 16'h0005;
  localparam logic [15:0] OP_SOFT_RESET = 16'h00ff;
  localparam int BR_OFS_W = 8;
  localparam int CALL_OFS_W = 11;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
  localparam logic [4:0] FLAGS_RESET = 5'h00;
  localparam int FLAG_C = 0;
  localparam int FLAG_N = 4;
  localparam logic [1:0] Q1 = 2'h0;
  localparam logic [1:0] Q2 = 2'h1;
  localparam logic [1:0] Q3 = 2'h2;
  localparam logic [1:0] Q4 = 2'h3;
endpackage : branch_stack_pkg

/* verilog/return_stack.sv */
// Purpose: Hardware return stack with push and pop
// Assumes: Overflow and underflow are handled elsewhere
// Notes: Top entry is registered for a flop-driven output
`timescale 1ns/1ps
`default_nettype none
module return_stack
  import branch_stack_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic push,
  input wire logic pop,
  input wire logic [PC_W-1:0] push_data,
  // Status
  output logic [PC_W-1:0] top_ff,
  output logic [STK_PTR_W-1:0] ptr_ff
);
  logic [PC_W-1:0] mem_ff [STK_DEPTH];
  logic [PC_W-1:0] nxt_top;
  logic [STK_PTR_W-1:0] nxt_ptr;
  logic [STK_PTR_W-1:0] below;

  assign below = ptr_ff - 5'h01;

  always_comb begin
    nxt_top = top_ff;
    nxt_ptr = ptr_ff;
    if (push) begin
      nxt_top = push_data;
      nxt_ptr = ptr_ff + 5'h01;
    end else if (pop) begin
      nxt_top = (ptr_ff > 5'h01) ? mem_ff[below - 5'h01] : PC_RESET;
      nxt_ptr = ptr_ff - 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      top_ff <= PC_RESET;
      ptr_ff <= '0;
    end else begin
      top_ff <= nxt_top;
      ptr_ff <= nxt_ptr;
    end
  end

  // Old top stays in memory below the new entry
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[ptr_ff] <= push_data;
    end
  end
endmodule : return_stack
`default_nettype wire

/* verilog/branch_stack_exec.sv */
// Purpose: Executes conditional branches, push, pop, relative call and soft reset
// Assumes: One instruction cycle is four quarter phases of CLK
// Notes: Instruction and flags are held stable by fetch for the whole cycle
`timescale 1ns/1ps
`default_nettype none
module branch_stack_exec
  import branch_stack_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Instruction in
  input wire logic [15:0] INSTR,
  input wire logic INSTR_VALID,
  input wire logic [4:0] FLAGS_IN,
  // Program counter and stack
  output logic [PC_W-1:0] PC,
  output logic [PC_W-1:0] TOP_OF_STACK,
  output logic [STK_PTR_W-1:0] STACK_DEPTH,
  // Status and reset
  output logic [4:0] FLAGS_OUT,
  output logic SOFT_RESET,
  output logic BUSY,
  output logic [1:0] QPHASE
);
  // ==========================================================
  // Phase and state
  // ==========================================================
  typedef enum logic [1:0] {IDLE, EXEC, FLUSH} state_e;
  state_e state_ff, nxt_state;
  logic [1:0] q_ff, nxt_q;
  logic [15:0] ir_ff, nxt_ir;
  logic [PC_W-1:0] pc_ff, nxt_pc;
  logic [PC_W-1:0] ofs_ff, nxt_ofs;
  logic [4:0] flags_ff, nxt_flags;
  logic rst_ff, nxt_rst;
  logic taken_ff, nxt_taken;
  logic stk_push, stk_pop;
  logic [PC_W-1:0] top_w;
  logic [STK_PTR_W-1:0] ptr_w;
  logic is_bn, is_bnc, is_bnn, is_call, is_pop, is_push, is_rst, cond;

  assign is_bn = ir_ff[15:8] == OP_BRANCH_NEG;
  assign is_bnc = ir_ff[15:8] == OP_BRANCH_NOT_CARRY;
  assign is_bnn = ir_ff[15:8] == OP_BRANCH_NOT_NEG;
  assign is_call = ir_ff[15:11] == OP_REL_CALL;
  assign is_pop = ir_ff == OP_STACK_POP;
  assign is_push = ir_ff == OP_STACK_PUSH;
  assign is_rst = ir_ff == OP_SOFT_RESET;
  assign cond = (is_bn && flags_ff[FLAG_N]) || (is_bnc && !flags_ff[FLAG_C])
    || (is_bnn && !flags_ff[FLAG_N]);

  // ==========================================================
  // Sequencing
  // ==========================================================
  always_comb begin
    nxt_state = state_ff;
    nxt_q = q_ff + 2'h1;
    nxt_ir = ir_ff;
    nxt_pc = pc_ff;
    nxt_ofs = ofs_ff;
    nxt_flags = flags_ff;
    nxt_rst = 1'b0;
    nxt_taken = taken_ff;
    stk_push = 1'b0;
    stk_pop = 1'b0;
    case (state_ff)
      IDLE: begin
        if (q_ff == Q4 && INSTR_VALID) begin
          nxt_ir = INSTR;
          nxt_flags = FLAGS_IN;
          nxt_state = EXEC;
        end
      end
      EXEC: begin
        case (q_ff)
          Q1: nxt_pc = pc_ff + PC_STEP;
          Q2: begin
            if (is_call) begin
              nxt_ofs = PC_W'($signed(ir_ff[CALL_OFS_W-1:0])) << 1;
              stk_push = 1'b1;
            end else begin
              nxt_ofs = PC_W'($signed(ir_ff[BR_OFS_W-1:0])) << 1;
            end
            if (is_push) stk_push = 1'b1;
            if (is_rst) nxt_rst = 1'b1;
          end
          Q3: begin
            nxt_taken = cond || is_call;
            if (is_pop) stk_pop = 1'b1;
          end
          Q4: begin
            if (taken_ff) begin
              nxt_pc = pc_ff + ofs_ff;
              nxt_state = FLUSH;
            end else begin
              nxt_state = IDLE;
            end
          end
          default: nxt_state = IDLE;
        endcase
      end
      FLUSH: begin
        if (q_ff == Q4) nxt_state = IDLE;
      end
      default: nxt_state = IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST || rst_ff) begin
      state_ff <= IDLE;
      q_ff <= Q1;
      ir_ff <= '0;
      pc_ff <= PC_RESET;
      ofs_ff <= '0;
      flags_ff <= FLAGS_RESET;
      rst_ff <= 1'b0;
      taken_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      q_ff <= nxt_q;
      ir_ff <= nxt_ir;
      pc_ff <= nxt_pc;
      ofs_ff <= nxt_ofs;
      flags_ff <= nxt_flags;
      rst_ff <= nxt_rst;
      taken_ff <= nxt_taken;
    end
  end

  return_stack u_stack (
    .clk(CLK),
    .rst(SYS_RST || rst_ff),
    .push(stk_push),
    .pop(stk_pop),
    .push_data(pc_ff),
    .top_ff(top_w),
    .ptr_ff(ptr_w)
  );

  // ==========================================================
  // Outputs
  // ==========================================================
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      PC <= PC_RESET;
      TOP_OF_STACK <= PC_RESET;
      STACK_DEPTH <= '0;
      FLAGS_OUT <= FLAGS_RESET;
      SOFT_RESET <= 1'b0;
      BUSY <= 1'b0;
      QPHASE <= Q1;
    end else begin
      PC <= pc_ff;
      TOP_OF_STACK <= top_w;
      STACK_DEPTH <= ptr_w;
      FLAGS_OUT <= flags_ff;
      SOFT_RESET <= rst_ff;
      BUSY <= state_ff != IDLE;
      QPHASE <= q_ff;
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  taken_target_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (state_ff == EXEC && q_ff == Q4 && taken_ff && !rst_ff) |=> pc_ff == $past(pc_ff) + $past(ofs_ff))
    else $error("branch target wrong");
  bn_cond_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (state_ff == EXEC && q_ff == Q3 && is_bn) |=> taken_ff == $past(flags_ff[FLAG_N]))
    else $error("negative branch decision wrong");
  bnc_cond_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (state_ff == EXEC && q_ff == Q3 && is_bnc) |=> taken_ff == !$past(flags_ff[FLAG_C]))
    else $error("not carry decision wrong");
  bnn_cond_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (state_ff == EXEC && q_ff == Q3 && is_bnn) |=> taken_ff == !$past(flags_ff[FLAG_N]))
    else $error("not negative decision wrong");
  flush_len_a: assert property (@(posedge CLK) disable iff (SYS_RST || rst_ff)
    (state_ff == EXEC && q_ff == Q4 && taken_ff) |=> (state_ff == FLUSH) [*4] ##1 state_ff == IDLE)
    else $error("taken branch idle cycle wrong");
  push_top_a: assert property (@(posedge CLK) disable iff (SYS_RST || rst_ff)
    stk_push |=> top_w == $past(pc_ff) && ptr_w == $past(ptr_w) + 5'h01)
    else $error("push did not store return address");
  pop_depth_a: assert property (@(posedge CLK) disable iff (SYS_RST || rst_ff)
    stk_pop |=> ptr_w == $past(ptr_w) - 5'h01 && flags_ff == $past(flags_ff))
    else $error("pop wrong");
  soft_reset_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (state_ff == EXEC && q_ff == Q2 && is_rst) |=> rst_ff ##1 (pc_ff == PC_RESET && flags_ff == FLAGS_RESET))
    else $error("soft reset not applied");
  reset_phase_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    rst_ff |-> $past(q_ff) == Q2 && $past(is_rst))
    else $error("soft reset launched outside second phase");
  call_return_a: assert property (@(posedge CLK) disable iff (SYS_RST || rst_ff)
    (state_ff == EXEC && q_ff == Q2 && is_call) |=> top_w == pc_ff)
    else $error("call return address not pushed before jump");
  flags_hold_a: assert property (@(posedge CLK) disable iff (SYS_RST || rst_ff)
    (state_ff != IDLE) |=> flags_ff == $past(flags_ff))
    else $error("status flags changed by instruction group");
  flush_idle_a: assert property (@(posedge CLK) disable iff (SYS_RST || rst_ff)
    (state_ff == FLUSH) |=> pc_ff == $past(pc_ff) && ptr_w == $past(ptr_w))
    else $error("idle cycle changed state");
  phase_wrap_a: assert property (@(posedge CLK) disable iff (SYS_RST || rst_ff)
    (q_ff == Q4) |=> q_ff == Q1)
    else $error("quarter phase did not wrap");
endmodule : branch_stack_exec
`default_nettype wire

/* verif/tb_top.sv */
// Purpose: Self-checking bench for the branch, stack and soft reset executor
// Assumes: One instruction cycle is four CLK periods; outputs lag one edge
// Notes: Busy length of a plain instruction is the baseline for cycle counts
`timescale 1ns/1ps
`default_nettype none
module tb_top import branch_stack_pkg::*; ;
  // ==========================================================================
  // Signals and tables
  logic CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic INSTR_VALID = 1'b0;
  logic [15:0] INSTR = 16'h0000;
  logic [4:0] FLAGS_IN = 5'h00;
  logic [4:0] FLAGS_OUT;
  logic [PC_W-1:0] PC, TOP_OF_STACK, pc_exp;
  logic [STK_PTR_W-1:0] STACK_DEPTH;
  logic SOFT_RESET, BUSY;
  logic [1:0] QPHASE;
  logic [PC_W-1:0] stk[$];
  int failures = 0;
  int n_tests = 0;
  int cycles = 0;
  int busy_cnt = 0;
  int pulse_cnt = 0;
  int base, blen, pulses;
  localparam logic [7:0] BR_OP [6] = '{OP_BRANCH_NEG, OP_BRANCH_NEG, OP_BRANCH_NOT_CARRY,
    OP_BRANCH_NOT_CARRY, OP_BRANCH_NOT_NEG, OP_BRANCH_NOT_NEG};
  localparam logic [7:0] BR_OFS [6] = '{8'h7f, 8'h80, 8'h80, 8'h7f, 8'h01, 8'hff};
  localparam logic [4:0] BR_FL [6] = '{5'h10, 5'h0f, 5'h1e, 5'h01, 5'h0f, 5'h10};
  localparam logic BR_TK [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};

  always #2 CLK = ~CLK;

  branch_stack_exec uut (.CLK(CLK), .SYS_RST(SYS_RST), .INSTR(INSTR),
    .INSTR_VALID(INSTR_VALID), .FLAGS_IN(FLAGS_IN), .PC(PC), .TOP_OF_STACK(TOP_OF_STACK),
    .STACK_DEPTH(STACK_DEPTH), .FLAGS_OUT(FLAGS_OUT), .SOFT_RESET(SOFT_RESET),
    .BUSY(BUSY), .QPHASE(QPHASE));

  // ==========================================================================
  // Cycle counters and hang limit
  always @(posedge CLK) begin
    cycles++;
    busy_cnt += (BUSY === 1'b1);
    pulse_cnt += (SOFT_RESET === 1'b1);
    if (cycles == 3000) begin
      failures++;
      tally_and_finish();
    end
  end

  // ==========================================================================
  // Shared tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("comparisons %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  // Issue one word, wait for the block to finish, measure busy and pulses
  task automatic run(input logic [15:0] ins, input logic [4:0] fl);
    int g, b0, p0;
    g = 0;
    @(posedge CLK);
    INSTR <= ins;
    FLAGS_IN <= fl;
    INSTR_VALID <= 1'b1;
    #1;
    b0 = busy_cnt;
    p0 = pulse_cnt;
    while (BUSY !== 1'b1 && g < 20) begin
      @(posedge CLK);
      #1;
      g++;
    end
    check("phase at start", QPHASE, Q1);
    @(posedge CLK) INSTR_VALID <= 1'b0;
    while (BUSY !== 1'b0 && g < 40) begin
      @(posedge CLK);
      #1;
      g++;
    end
    repeat (2) @(posedge CLK);
    #1;
    blen = busy_cnt - b0;
    pulses = pulse_cnt - p0;
    if (ins != OP_SOFT_RESET) check("flags kept", FLAGS_OUT, fl);
    if (ins != OP_SOFT_RESET) check("no reset pulse", pulses, 0);
  endtask : run

  // ==========================================================================
  // Scenarios
  task automatic t_plain();
    run(16'hffff, 5'h15);
    pc_exp = pc_exp + PC_STEP;
    check("plain pc", PC, pc_exp);
    base = blen;
  endtask : t_plain

  task automatic t_branch();
    for (int i = 0; i < 6; i++) begin
      run({BR_OP[i], BR_OFS[i]}, BR_FL[i]);
      pc_exp = pc_exp + PC_STEP + (BR_TK[i] ? {{12{BR_OFS[i][7]}}, BR_OFS[i], 1'b0} : '0);
      check("branch pc", PC, pc_exp);
      check("branch cycles", blen, base + (BR_TK[i] ? 4 : 0));
      check("branch stack", STACK_DEPTH, 0);
    end
  endtask : t_branch

  task automatic t_stack();
    logic [10:0] cofs [2];
    cofs = '{11'h400, 11'h3ff};
    for (int i = 0; i < 3; i++) begin
      stk.push_front(pc_exp + PC_STEP);
      run(OP_STACK_PUSH, 5'h0a);
      pc_exp = pc_exp + PC_STEP;
      check("push top", TOP_OF_STACK, stk[0]);
      check("push depth", STACK_DEPTH, stk.size());
      check("push cycles", blen, base);
    end
    for (int i = 0; i < 2; i++) begin
      stk.push_front(pc_exp + PC_STEP);
      run({OP_REL_CALL, cofs[i]}, 5'h11);
      pc_exp = pc_exp + PC_STEP + {{9{cofs[i][10]}}, cofs[i], 1'b0};
      check("call pc", PC, pc_exp);
      check("call return", TOP_OF_STACK, stk[0]);
      check("call depth", STACK_DEPTH, stk.size());
      check("call cycles", blen, base + 4);
    end
    for (int i = 0; i < 3; i++) begin
      void'(stk.pop_front());
      run(OP_STACK_POP, 5'h04);
      pc_exp = pc_exp + PC_STEP;
      check("pop top", TOP_OF_STACK, stk[0]);
      check("pop depth", STACK_DEPTH, stk.size());
      check("pop cycles", blen, base);
      check("pop pc", PC, pc_exp);
    end
  endtask : t_stack

  task automatic t_soft();
    run(OP_SOFT_RESET, 5'h1f);
    check("reset pulse", pulses, 1);
    check("reset pc", PC, PC_RESET);
    check("reset top", TOP_OF_STACK, 0);
    check("reset depth", STACK_DEPTH, 0);
    check("reset flags", FLAGS_OUT, FLAGS_RESET);
  endtask : t_soft

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge CLK);
    SYS_RST <= 1'b0;
    pc_exp = PC_RESET;
    t_plain();
    t_branch();
    t_stack();
    t_soft();
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
